// >>> pkg/twm_defines.svh
// Purpose: constants for the timer waveform mode control block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: all offsets are byte addresses
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH
`define TWM_OFF_CTRL_A 8'h00
`define TWM_OFF_CTRL_B 8'h04
`define TWM_OFF_CMP_A 8'h08
`define TWM_OFF_CMP_B 8'h0c
`define TWM_OFF_STATUS 8'h10
`define TWM_CTRL_A_MASK 8'hf3
`define TWM_CTRL_B_MASK 8'h08
`define TWM_CTRL_B_WMHI 3
`define TWM_CTRL_A_RESET 8'h00
`define TWM_CNT_BOTTOM 8'h00
`define TWM_CNT_MAX 8'hff
`define TWM_ACT_OFF 2'h0
`define TWM_ACT_TOG 2'h1
`define TWM_ACT_CLR 2'h2
`define TWM_ACT_SET 2'h3
`define TWM_RESP_OKAY 2'h0
`define TWM_RESP_SLVERR 2'h2
`endif

// >>> pkg/twm_pkg.sv
// Purpose: shared types for the timer waveform mode control block
// Assumes: nothing beyond the defines header
// Notes: modes carry implicit codes 0 to 7 in listed order; decode maps the field to these
package twm_pkg;
   typedef enum logic [2:0] {
      TWM_NORMAL,
      TWM_PCPWM_FF,
      TWM_CTC,
      TWM_FPWM_FF,
      TWM_RSVD4,
      TWM_PCPWM_A,
      TWM_RSVD6,
      TWM_FPWM_A
   } twm_mode_e;
   typedef enum logic [1:0] {
      TWM_KIND_NONPWM,
      TWM_KIND_FAST,
      TWM_KIND_PHASE,
      TWM_KIND_IDLE
   } twm_kind_e;
endpackage

// >>> rtl/twm_mode_decode.sv
// Purpose: decode the three-bit wave mode into top, update and flag policy
// Assumes: mode bits come from registers on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_mode_decode
   import twm_pkg::*;
(
   input wire logic [2:0] waveMode, // combined mode field
   input wire logic [7:0] cmpValueA, // compare value a
   output twm_kind_e kind, // waveform kind
   output logic [7:0] topValue, // counter top
   output logic topIsCmpA, // top taken from compare a
   output logic updateAtTop, // compare values reload at top
   output logic ovfAtBottom // overflow flag at bottom, else max
);
   always_comb begin
      kind = TWM_KIND_IDLE;
      topValue = `TWM_CNT_MAX;
      topIsCmpA = 1'b0;
      updateAtTop = 1'b0;
      ovfAtBottom = 1'b0;
      case (twm_mode_e'(waveMode))
         TWM_NORMAL: begin
            kind = TWM_KIND_NONPWM;
         end
         TWM_CTC: begin
            kind = TWM_KIND_NONPWM;
            topIsCmpA = 1'b1;
         end
         TWM_FPWM_FF, TWM_FPWM_A: begin
            kind = TWM_KIND_FAST;
            updateAtTop = 1'b1;
            topIsCmpA = waveMode[2];
         end
         TWM_PCPWM_FF, TWM_PCPWM_A: begin
            kind = TWM_KIND_PHASE;
            updateAtTop = 1'b1;
            ovfAtBottom = 1'b1;
            topIsCmpA = waveMode[2];
         end
         default: begin
            kind = TWM_KIND_IDLE;
         end
      endcase
      if (topIsCmpA) begin
         topValue = cmpValueA;
      end
   end
endmodule

// >>> rtl/twm_out_unit.sv
// Purpose: one compare output channel: action decode and output latch
// Assumes: match, top and direction come from the counter on this clock
// Notes: reserved codes and idle modes leave the output unchanged
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_out_unit
   import twm_pkg::*;
#(
   parameter bit TOGGLE_IN_PWM = 1'b1 // channel a may toggle in pwm
)(
   input wire logic ref_clk, // clock
   input wire logic rstn, // async reset, active low
   input wire logic [1:0] action, // output action field
   input wire twm_kind_e kind, // waveform kind
   input wire logic modeHi, // high mode bit
   input wire logic cmpMatch, // counter equals compare value
   input wire logic cmpIsTop, // compare value equals top
   input wire logic atTop, // counter at top
   input wire logic countDown, // phase pwm counting down
   input wire logic force_, // forced compare strobe
   output logic pinOverride, // channel owns the pin
   output logic outLevel // output latch
);
   logic next_outLevel;
   logic hit;
   always_comb begin
      next_outLevel = outLevel;
      pinOverride = (action != `TWM_ACT_OFF);
      hit = cmpMatch;
      if (kind != TWM_KIND_NONPWM && action[1] && cmpIsTop) begin
         hit = 1'b0;
      end
      case (kind)
         TWM_KIND_NONPWM: begin
            if (cmpMatch || force_) begin
               case (action)
                  `TWM_ACT_TOG: next_outLevel = ~outLevel;
                  `TWM_ACT_CLR: next_outLevel = 1'b0;
                  `TWM_ACT_SET: next_outLevel = 1'b1;
                  default: next_outLevel = outLevel;
               endcase
            end
         end
         TWM_KIND_FAST: begin
            if (action == `TWM_ACT_TOG) begin
               pinOverride = TOGGLE_IN_PWM && modeHi;
               if (pinOverride && cmpMatch) begin
                  next_outLevel = ~outLevel;
               end
            end else if (action[1]) begin
               if (hit) begin
                  next_outLevel = ~action[0] ? 1'b0 : 1'b1;
               end else if (atTop) begin
                  next_outLevel = ~action[0];
               end
            end
         end
         TWM_KIND_PHASE: begin
            if (action == `TWM_ACT_TOG) begin
               pinOverride = TOGGLE_IN_PWM && modeHi;
               if (pinOverride && cmpMatch) begin
                  next_outLevel = ~outLevel;
               end
            end else if (action[1]) begin
               if (hit) begin
                  next_outLevel = action[0] ^ countDown;
               end else if (cmpIsTop && atTop) begin
                  next_outLevel = action[0] ^ 1'b1;
               end
            end
         end
         default: begin
            next_outLevel = outLevel;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         outLevel <= 1'b0;
      end else begin
         outLevel <= next_outLevel;
      end
   end
endmodule

// >>> rtl/twm_top.sv
// Purpose: waveform mode control registers with AXI4-Lite access
// Assumes: counter value, direction and strobes come from the timer core
// Notes:
// Summary of operation
// - nonzero output action hands the pin to the compare output, except pwm 01 on b, or on a with mode high bit 0
// - non-pwm channel a: off, toggle, clear, set on match
// - non-pwm channel b uses the same four-way decode
// - fast pwm a: clear on match set at top, or inverse
// - pwm action 01 on a: off if mode high bit 0, else toggle
// - fast pwm b: 01 reserved, 10/11 as channel a
// - phase pwm a: 10 clear up-match set down-match, 11 inverse
// - phase pwm b: 01 reserved, 10/11 as channel a
// - pwm compare a equal top with high action bit: only top action
// - pwm compare b equal top with high action bit: only top action
// - control a bits 3 and 2 ignore writes, read zero
// - two low mode bits plus control b bit form the mode
// - mode 0 top ff, mode 2 top compare a, immediate, flag at max
// - fast pwm modes 3 and 7, reload at top, flag at max
// - phase pwm modes 1 and 5, reload at top, flag at bottom
// - bottom is zero, max is all ones
// - high mode bit sits at bit three of control b
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_top
   import twm_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rstn, // async reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [7:0] count, // counter value from core
   input wire logic countDown, // core counting down
   input wire logic forceA, // forced compare a strobe
   input wire logic forceB, // forced compare b strobe
   output logic [2:0] waveMode, // combined mode to core
   output logic [7:0] topValue, // counter top to core
   output logic ovfAtBottom, // overflow flag point to core
   output logic cmpOutAPin, // compare output a level
   output logic cmpOutAEn, // compare output a owns pin
   output logic cmpOutBPin, // compare output b level
   output logic cmpOutBEn // compare output b owns pin
);
   logic [7:0] ctrlA, next_ctrlA;
   logic [7:0] ctrlB, next_ctrlB;
   logic [7:0] cmpBufA, next_cmpBufA;
   logic [7:0] cmpBufB, next_cmpBufB;
   logic [7:0] cmpValueA, next_cmpValueA;
   logic [7:0] cmpValueB, next_cmpValueB;
   logic awHeld, next_awHeld;
   logic wHeld, next_wHeld;
   logic [7:0] awAddr, next_awAddr;
   logic [7:0] wByte, next_wByte;
   logic wLane, next_wLane;
   logic bValid, next_bValid;
   logic [1:0] bResp, next_bResp;
   logic rValid, next_rValid;
   logic [31:0] rData, next_rData;
   logic [1:0] rResp, next_rResp;
   logic doWrite;
   logic [1:0] act;
   logic topIsCmpA, updateAtTop, atTop;
   twm_kind_e kind;
   assign waveMode = {ctrlB[`TWM_CTRL_B_WMHI], ctrlA[1:0]};
   assign atTop = (count == topValue);
   twm_mode_decode u_dec (
      .waveMode(waveMode),
      .cmpValueA(cmpValueA),
      .kind(kind),
      .topValue(topValue),
      .topIsCmpA(topIsCmpA),
      .updateAtTop(updateAtTop),
      .ovfAtBottom(ovfAtBottom)
   );
   twm_out_unit #(.TOGGLE_IN_PWM(1'b1)) u_outA (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .action(ctrlA[7:6]),
      .kind(kind),
      .modeHi(waveMode[2]),
      .cmpMatch(count == cmpValueA),
      .cmpIsTop(cmpValueA == topValue),
      .atTop(atTop),
      .countDown(countDown),
      .force_(forceA),
      .pinOverride(cmpOutAEn),
      .outLevel(cmpOutAPin)
   );
   twm_out_unit #(.TOGGLE_IN_PWM(1'b0)) u_outB (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .action(ctrlA[5:4]),
      .kind(kind),
      .modeHi(waveMode[2]),
      .cmpMatch(count == cmpValueB),
      .cmpIsTop(cmpValueB == topValue),
      .atTop(atTop),
      .countDown(countDown),
      .force_(forceB),
      .pinOverride(cmpOutBEn),
      .outLevel(cmpOutBPin)
   );
   assign act = ctrlA[7:6];
   assign s_axi_awready = !awHeld && !bValid;
   assign s_axi_wready = !wHeld && !bValid;
   assign s_axi_bvalid = bValid;
   assign s_axi_bresp = bResp;
   assign s_axi_arready = !rValid;
   assign s_axi_rvalid = rValid;
   assign s_axi_rdata = rData;
   assign s_axi_rresp = rResp;
   assign doWrite = awHeld && wHeld && !bValid;
   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awAddr = awAddr;
      next_wByte = wByte;
      next_wLane = wLane;
      next_bValid = bValid;
      next_bResp = bResp;
      next_ctrlA = ctrlA;
      next_ctrlB = ctrlB;
      next_cmpBufA = cmpBufA;
      next_cmpBufB = cmpBufB;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wByte = s_axi_wdata[7:0];
         next_wLane = s_axi_wstrb[0];
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bValid = 1'b1;
         next_bResp = `TWM_RESP_OKAY;
         case (awAddr)
            `TWM_OFF_CTRL_A: begin
               if (wLane) begin
                  next_ctrlA = wByte & `TWM_CTRL_A_MASK;
               end
            end
            `TWM_OFF_CTRL_B: begin
               if (wLane) begin
                  next_ctrlB = wByte & `TWM_CTRL_B_MASK;
               end
            end
            `TWM_OFF_CMP_A: begin
               if (wLane) begin
                  next_cmpBufA = wByte;
               end
            end
            `TWM_OFF_CMP_B: begin
               if (wLane) begin
                  next_cmpBufB = wByte;
               end
            end
            `TWM_OFF_STATUS: begin
               next_bResp = `TWM_RESP_OKAY;
            end
            default: begin
               next_bResp = `TWM_RESP_SLVERR;
            end
         endcase
      end else if (bValid && s_axi_bready) begin
         next_bValid = 1'b0;
      end
   end
   // compare values: immediate in non-pwm modes, at top in pwm modes
   always_comb begin
      next_cmpValueA = cmpValueA;
      next_cmpValueB = cmpValueB;
      if (!updateAtTop || atTop) begin
         next_cmpValueA = cmpBufA;
         next_cmpValueB = cmpBufB;
      end
   end
   always_comb begin
      next_rValid = rValid;
      next_rData = rData;
      next_rResp = rResp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rValid = 1'b1;
         next_rResp = `TWM_RESP_OKAY;
         next_rData = 32'h0000_0000;
         case (s_axi_araddr)
            `TWM_OFF_CTRL_A: next_rData = {24'h00_0000, ctrlA};
            `TWM_OFF_CTRL_B: next_rData = {24'h00_0000, ctrlB};
            `TWM_OFF_CMP_A: next_rData = {24'h00_0000, cmpBufA};
            `TWM_OFF_CMP_B: next_rData = {24'h00_0000, cmpBufB};
            `TWM_OFF_STATUS: begin
               next_rData = {16'h0000, topValue, 2'h0, kind,
                  cmpOutBEn, cmpOutBPin, cmpOutAEn, cmpOutAPin};
            end
            default: begin
               next_rResp = `TWM_RESP_SLVERR;
            end
         endcase
      end else if (rValid && s_axi_rready) begin
         next_rValid = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrlA <= `TWM_CTRL_A_RESET;
         ctrlB <= 8'h00;
         cmpBufA <= 8'h00;
         cmpBufB <= 8'h00;
         cmpValueA <= 8'h00;
         cmpValueB <= 8'h00;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wByte <= 8'h00;
         wLane <= 1'b0;
         bValid <= 1'b0;
         bResp <= 2'h0;
         rValid <= 1'b0;
         rData <= 32'h0000_0000;
         rResp <= 2'h0;
      end else begin
         ctrlA <= next_ctrlA;
         ctrlB <= next_ctrlB;
         cmpBufA <= next_cmpBufA;
         cmpBufB <= next_cmpBufB;
         cmpValueA <= next_cmpValueA;
         cmpValueB <= next_cmpValueB;
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddr <= next_awAddr;
         wByte <= next_wByte;
         wLane <= next_wLane;
         bValid <= next_bValid;
         bResp <= next_bResp;
         rValid <= next_rValid;
         rData <= next_rData;
         rResp <= next_rResp;
      end
   end
   property p_ovr_a;
      @(posedge ref_clk) disable iff (!rstn)
      (kind == TWM_KIND_NONPWM) |-> (cmpOutAEn == (act != 2'h0));
   endproperty
   a_ovr_a: assert property (p_ovr_a)
      else $error("pin a ownership wrong");
   property p_rsvd;
      @(posedge ref_clk) disable iff (!rstn)
      1'b1 |-> (ctrlA[3:2] == 2'h0);
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits nonzero");
   property p_set_a;
      @(posedge ref_clk) disable iff (!rstn)
      (kind == TWM_KIND_NONPWM && act == 2'h3 && count == cmpValueA)
         |=> cmpOutAPin;
   endproperty
   a_set_a: assert property (p_set_a)
      else $error("set on match failed");
   property p_clr_a;
      @(posedge ref_clk) disable iff (!rstn)
      (kind == TWM_KIND_NONPWM && act == 2'h2 && count == cmpValueA)
         |=> !cmpOutAPin;
   endproperty
   a_clr_a: assert property (p_clr_a)
      else $error("clear on match failed");
   property p_tog_a;
      @(posedge ref_clk) disable iff (!rstn)
      (kind == TWM_KIND_NONPWM && act == 2'h1 && count == cmpValueA
         && !forceA) |=> (cmpOutAPin != $past(cmpOutAPin));
   endproperty
   a_tog_a: assert property (p_tog_a) else $error("toggle failed");
   property p_fast_top;
      @(posedge ref_clk) disable iff (!rstn)
      (kind == TWM_KIND_FAST && act == 2'h2 && atTop
         && count != cmpValueA) |=> cmpOutAPin;
   endproperty
   a_fast_top: assert property (p_fast_top)
      else $error("set at top failed");
   property p_top_ff;
      @(posedge ref_clk) disable iff (!rstn)
      (waveMode == 3'h0 || waveMode == 3'h3 || waveMode == 3'h1)
         |-> (topValue == 8'hff);
   endproperty
   a_top_ff: assert property (p_top_ff) else $error("top not max");
   property p_top_cmp;
      @(posedge ref_clk) disable iff (!rstn)
      (waveMode == 3'h2 || waveMode == 3'h5 || waveMode == 3'h7)
         |-> (topIsCmpA && topValue == cmpValueA);
   endproperty
   a_top_cmp: assert property (p_top_cmp)
      else $error("top not compare a");
   property p_ovf;
      @(posedge ref_clk) disable iff (!rstn)
      ovfAtBottom |-> (waveMode == 3'h1 || waveMode == 3'h5);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow point wrong");
   property p_idle;
      @(posedge ref_clk) disable iff (!rstn)
      (waveMode == 3'h4 || waveMode == 3'h6) |=> $stable(cmpOutBPin);
   endproperty
   a_idle: assert property (p_idle)
      else $error("reserved mode moved output");
endmodule

// >>> dv/twm_pin_load.sv
// Purpose: model of a port pin that a compare output may drive
// Assumes: dirOut is the pin-direction bit that software sets
// Notes: an undriven input pin sits at its weak pull-up
`timescale 1ns/1ps
module twm_pin_load (
   input wire logic cmpLevel, // compare output latch level
   input wire logic cmpEn, // compare output owns the pin
   input wire logic dirOut, // pin direction set to output
   input wire logic portLevel, // normal port function level
   output logic padLevel // level seen by the external load
);
   // waveform reaches the pad only when direction is output
   always_comb begin
      if (!dirOut) begin
         padLevel = 1'b1;
      end else if (cmpEn) begin
         padLevel = cmpLevel;
      end else begin
         padLevel = portLevel;
      end
   end
endmodule

// >>> dv/twm_top_tb.sv
// Purpose: self-checking bench for the waveform mode control block
// Assumes: bus inputs change only just after a rising edge
// Notes: handshakes are sampled at the rising edge they complete on
`timescale 1ns/1ps
`include "twm_defines.svh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin \
   bad_count++; $display("mismatch %0t %s", $time, m); end end
module twm_top_tb;
   logic ref_clk = 1'b0, rstn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastResp, act;
   logic [7:0] count = 8'h10, topValue;
   logic countDown = 1'b0, forceA = 1'b0, forceB = 1'b0;
   logic [2:0] waveMode;
   logic ovfAtBottom, cmpOutAPin, cmpOutAEn, cmpOutBPin, cmpOutBEn;
   logic dirOut = 1'b1, portLevel = 1'b0, padA, padB, exp;
   logic [31:0] rdData;
   logic [1:0] expKind;
   int bad_count = 0, check_count = 0;
   always #2.5 ref_clk = ~ref_clk;
   twm_top twm_top_inst (.ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .count(count), .countDown(countDown),
      .forceA(forceA), .forceB(forceB), .waveMode(waveMode),
      .topValue(topValue), .ovfAtBottom(ovfAtBottom),
      .cmpOutAPin(cmpOutAPin), .cmpOutAEn(cmpOutAEn),
      .cmpOutBPin(cmpOutBPin), .cmpOutBEn(cmpOutBEn));
   twm_pin_load twm_pin_load_inst (.cmpLevel(cmpOutAPin),
      .cmpEn(cmpOutAEn), .dirOut(dirOut), .portLevel(portLevel),
      .padLevel(padA));
   twm_pin_load twm_pin_load_b_inst (.cmpLevel(cmpOutBPin),
      .cmpEn(cmpOutBEn), .dirOut(dirOut), .portLevel(portLevel),
      .padLevel(padB));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         if (hb) lastResp = s_axi_bresp;
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) begin
            s_axi_bready <= 1'b0;
            return;
         end
      end
      `CHK(1'b0, 1'b1, "write hang")
   endtask
   task automatic rd(input logic [7:0] a);
      logic ha, hr;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid;
         if (hr) begin
            lastResp = s_axi_rresp;
            rdData = s_axi_rdata;
         end
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      `CHK(1'b0, 1'b1, "read hang")
   endtask
   task automatic setMode(input logic [2:0] m, input logic [1:0] aa,
                          input logic [1:0] ab);
      wr(`TWM_OFF_CTRL_A, {24'h0, aa, ab, 2'b00, m[1:0]});
      wr(`TWM_OFF_CTRL_B, {28'h0, m[2], 3'b000});
   endtask
   // one cycle of the counter at c, then back to a value matching nothing
   task automatic hit(input logic [7:0] c, input logic dn);
      @(posedge ref_clk);
      count <= c;
      countDown <= dn;
      @(posedge ref_clk);
      count <= 8'h10;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic pins(input logic ea, input logic eb);
      `CHK(cmpOutAPin, ea, "pin a level")
      `CHK(cmpOutBPin, eb, "pin b level")
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      $display("mismatch %0t watchdog expired", $time);
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(`TWM_OFF_CTRL_A);
      `CHK(rdData, 32'h0, "control a reset")
      `CHK(waveMode, 3'h0, "reset mode")
      `CHK(cmpOutAEn | cmpOutBEn, 1'b0, "reset enables")
      `CHK(padA, portLevel, "pad follows port")
      dirOut <= 1'b0;
      @(posedge ref_clk);
      `CHK(padA, 1'b1, "pad needs direction")
      dirOut <= 1'b1;
      wr(`TWM_OFF_CTRL_A, 32'hff);
      `CHK(lastResp, `TWM_RESP_OKAY, "write okay")
      rd(`TWM_OFF_CTRL_A);
      `CHK(rdData, 32'hf3, "reserved bits")
      `CHK(lastResp, `TWM_RESP_OKAY, "read okay")
      s_axi_wstrb <= 4'h0;
      wr(`TWM_OFF_CTRL_A, 32'h0);
      s_axi_wstrb <= 4'h1;
      rd(`TWM_OFF_CTRL_A);
      `CHK(rdData, 32'hf3, "lane off")
      rd(8'h14);
      `CHK(lastResp, `TWM_RESP_SLVERR, "unmapped read")
      `CHK(rdData, 32'h0, "unmapped data")
      wr(8'h14, 32'h1);
      `CHK(lastResp, `TWM_RESP_SLVERR, "unmapped write")
      $display("test registers done");
      setMode(3'd0, 2'h0, 2'h0);
      wr(`TWM_OFF_CMP_A, 32'h40);
      wr(`TWM_OFF_CMP_B, 32'h20);
      for (int m = 0; m < 8; m++) begin
         setMode(m[2:0], 2'h0, 2'h0);
         rd(`TWM_OFF_STATUS);
         `CHK(waveMode, m[2:0], "mode field")
         case (m)
            0, 2: expKind = 2'h0;
            3, 7: expKind = 2'h1;
            1, 5: expKind = 2'h2;
            default: expKind = 2'h3;
         endcase
         `CHK(rdData[5:4], expKind, "mode kind")
         if (expKind != 2'h3) begin
            `CHK(topValue, (m == 2 || m == 5 || m == 7) ? 8'h40 :
               `TWM_CNT_MAX, "top")
            `CHK(ovfAtBottom, m == 1 || m == 5, "ovf point")
         end
      end
      $display("test mode table done");
      exp = 1'b0;
      for (int i = 3; i >= 1; i--) begin
         act = i[1:0];
         setMode(3'd0, act, act);
         hit(8'h40, 1'b0);
         hit(8'h20, 1'b0);
         exp = (act == 2'h1) ? ~exp : act[0];
         `CHK(cmpOutAPin, exp, "nonpwm a")
         `CHK(cmpOutBPin, exp, "nonpwm b")
         `CHK({cmpOutAEn, cmpOutBEn}, 2'b11, "enables")
         `CHK(padA, exp, "pad a")
      end
      @(posedge ref_clk);
      {forceA, forceB} <= 2'b11;
      @(posedge ref_clk);
      {forceA, forceB} <= 2'b00;
      repeat (2) @(posedge ref_clk);
      pins(1'b0, 1'b0);
      setMode(3'd0, 2'h0, 2'h0);
      `CHK({cmpOutAEn, cmpOutBEn}, 2'b00, "disconnect")
      $display("test non-pwm done");
      setMode(3'd3, 2'h2, 2'h1);
      `CHK(cmpOutBEn, 1'b0, "fast b reserved")
      hit(8'h40, 1'b0);
      `CHK(cmpOutAPin, 1'b0, "fast a clear")
      hit(8'hff, 1'b0);
      pins(1'b1, 1'b0);
      setMode(3'd3, 2'h3, 2'h2);
      hit(8'h40, 1'b0);
      hit(8'h20, 1'b0);
      pins(1'b1, 1'b0);
      hit(8'hff, 1'b0);
      pins(1'b0, 1'b1);
      setMode(3'd3, 2'h1, 2'h0);
      `CHK(cmpOutAEn, 1'b0, "a toggle off")
      setMode(3'd7, 2'h1, 2'h0);
      `CHK(cmpOutAEn, 1'b1, "a toggle on")
      hit(8'h40, 1'b0);
      `CHK(cmpOutAPin, 1'b1, "a toggled")
      $display("test fast pwm done");
      setMode(3'd1, 2'h2, 2'h2);
      hit(8'h40, 1'b0);
      hit(8'h20, 1'b0);
      pins(1'b0, 1'b0);
      hit(8'h40, 1'b1);
      hit(8'h20, 1'b1);
      pins(1'b1, 1'b1);
      setMode(3'd1, 2'h3, 2'h3);
      hit(8'h40, 1'b1);
      hit(8'h20, 1'b1);
      pins(1'b0, 1'b0);
      hit(8'h40, 1'b0);
      hit(8'h20, 1'b0);
      pins(1'b1, 1'b1);
      setMode(3'd1, 2'h1, 2'h1);
      `CHK({cmpOutAEn, cmpOutBEn}, 2'b00, "phase 01")
      setMode(3'd5, 2'h0, 2'h1);
      `CHK(cmpOutBEn, 1'b0, "phase b reserved")
      $display("test phase pwm done");
      setMode(3'd4, 2'h2, 2'h2);
      hit(8'h40, 1'b0);
      hit(8'h20, 1'b0);
      pins(1'b1, 1'b1);
      $display("test reserved mode done");
      setMode(3'd0, 2'h2, 2'h2);
      wr(`TWM_OFF_CMP_A, 32'hff);
      wr(`TWM_OFF_CMP_B, 32'hff);
      hit(8'hff, 1'b0);
      pins(1'b0, 1'b0);
      setMode(3'd3, 2'h2, 2'h2);
      hit(8'hff, 1'b0);
      pins(1'b1, 1'b1);
      setMode(3'd1, 2'h3, 2'h3);
      hit(8'hff, 1'b0);
      pins(1'b0, 1'b0);
      $display("test compare at top done");
      print_verdict();
   end
endmodule
